//--- src/ast_transceiver.v
// Purpose: Asynchronous serial transmitter and receiver with fractional baud generator.
// Assumes: 40 MHz clk_in, synchronous active-high rst_in, serial input from a pin.
// Notes:   Divisor and line control take effect only on a line-control write.
`timescale 1ns/10ps
`include "ast_defs.vh"

module ast_transceiver #(
    parameter PORT_INDEX = 0,
    parameter QDEPTH     = 16,
    parameter QAW        = 4
)(
    input  wire                      clk_in,
    input  wire                      rst_in,
    input  wire                      ctl_wr_in,
    input  wire [`AST_CTL_W-1:0]     ctl_data_in,
    output reg  [`AST_CTL_W-1:0]     ctl_out,
    input  wire                      int_wr_in,
    input  wire [`AST_DIVI_W-1:0]    int_data_in,
    input  wire                      frac_wr_in,
    input  wire [`AST_DIVF_W-1:0]    frac_data_in,
    input  wire                      lcr_wr_in,
    input  wire [`AST_LCR_W-1:0]     lcr_data_in,
    output reg  [`AST_LATCH_W-1:0]   latched_out,
    input  wire                      tx_valid_in,
    input  wire [7:0]                tx_data_in,
    output wire                      tx_ready_out,
    output wire                      rx_valid_out,
    output wire [11:0]               rx_data_out,
    input  wire                      rx_ready_in,
    output reg                       busy_out,
    input  wire                      alt_function_select_in,
    input  wire                      gpio_out_in,
    output reg                       serial_function_out,
    input  wire                      port0_serial_in_in,
    output reg                       port0_serial_out_out
);
    localparam S_IDLE  = 5'h01;
    localparam S_START = 5'h02;
    localparam S_DATA  = 5'h04;
    localparam S_PAR   = 5'h08;
    localparam S_STOP  = 5'h10;

    reg  [`AST_DIVI_W-1:0] divisor_integer_reg;
    reg  [`AST_DIVF_W-1:0] divisor_fraction_reg;
    reg  [`AST_LCR_W-1:0]  lcr;
    reg  [`AST_DIVI_W:0]   tick_cnt;
    reg  [`AST_DIVF_W-1:0] frac_acc;
    reg                    oversample_tick;
    reg  [2:0]             rx_sync;
    reg                    rx_prev;
    reg  [3:0]             sir_hold;
    reg  [4:0]             tx_state;
    reg  [3:0]             tx_ovs;
    reg  [3:0]             tx_bit;
    reg  [7:0]             tx_shift;
    reg                    tx_line;
    reg  [4:0]             rx_state;
    reg  [3:0]             rx_ovs;
    reg  [3:0]             rx_bit;
    reg  [7:0]             rx_shift;
    reg                    rx_pe;
    reg                    rx_zero;
    reg                    oe_pend;
    reg                    rx_push;
    reg  [11:0]            rx_word;
    wire                   txq_valid;
    wire [7:0]             txq_data;
    reg                    txq_pop;
    wire                   rxq_ready;
    wire                   rxq_valid;
    wire [11:0]            rxq_data;
    wire                   rxb_ready;

    wire port_en  = ctl_out[`AST_CTL_EN];
    wire sir_en   = ctl_out[`AST_CTL_SIR];
    wire pen      = lcr[`AST_LCR_PEN];
    wire eps      = lcr[`AST_LCR_EPS];
    wire sps      = lcr[`AST_LCR_SPS];
    wire queue_enable_bit      = lcr[`AST_LCR_FEN];
    wire [3:0] nbits = `AST_MIN_BITS + {2'b00, lcr[`AST_LCR_WLEN_HI:`AST_LCR_WLEN_LO]};
    wire [`AST_DIVF_W:0] frac_sum = {1'b0, frac_acc} + {1'b0, latched_out[`AST_DIVF_W+7:8]};
    wire [`AST_DIVI_W-1:0] lat_int = latched_out[`AST_LATCH_W-1:`AST_DIVF_W+8];
    wire rx_line = sir_en ? (sir_hold == 4'h0) : rx_sync[2];

    // Parity of a word masked to the configured length, as sent on the line.
    function par_bit;
        input [7:0] d;
        input [3:0] n;
        input       even;
        input       stick;
        reg   [7:0] m;
        begin
            m = d & (8'hff >> (4'h8 - n));
            if (stick)
                par_bit = ~even;
            else
                par_bit = even ? ^m : ~^m;
        end
    endfunction

    // Software-visible registers; control enables reset set, port disabled.
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ctl_out              <= `AST_CTL_RESET;
            divisor_integer_reg  <= {`AST_DIVI_W{1'b0}};
            divisor_fraction_reg <= {`AST_DIVF_W{1'b0}};
            latched_out          <= {`AST_LATCH_W{1'b0}};
            serial_function_out  <= (PORT_INDEX == 0);
        end
        else
        begin
            if (ctl_wr_in)
                ctl_out <= ctl_data_in;
            if (int_wr_in)
                divisor_integer_reg <= int_data_in;
            if (frac_wr_in)
                divisor_fraction_reg <= frac_data_in;
            // The divisor only moves with a line-control write, so a half-written pair never runs.
            if (lcr_wr_in)
                latched_out <= {divisor_integer_reg, divisor_fraction_reg, lcr_data_in};
            serial_function_out <= (PORT_INDEX == 0) | alt_function_select_in;
        end
    end

    // Line control in use is the low byte of the latched word.
    always @*
    begin
        lcr = latched_out[`AST_LCR_W-1:0];
    end

    // Fractional divider: period is the integer part plus one whenever the fraction carries.
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            tick_cnt        <= {(`AST_DIVI_W+1){1'b0}};
            frac_acc        <= {`AST_DIVF_W{1'b0}};
            oversample_tick <= 1'b0;
        end
        else if (lat_int == {`AST_DIVI_W{1'b0}})
        begin
            tick_cnt        <= {(`AST_DIVI_W+1){1'b0}};
            oversample_tick <= 1'b0;
        end
        else if (tick_cnt <= {{`AST_DIVI_W{1'b0}}, 1'b1})
        begin
            oversample_tick <= 1'b1;
            frac_acc        <= frac_sum[`AST_DIVF_W-1:0];
            tick_cnt        <= {1'b0, lat_int} + {{`AST_DIVI_W{1'b0}}, frac_sum[`AST_DIVF_W]};
        end
        else
        begin
            oversample_tick <= 1'b0;
            tick_cnt        <= tick_cnt - 1'b1;
        end
    end

    // Receive pin synchroniser; the infrared decoder stretches each low pulse over one bit.
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rx_sync  <= 3'h7;
            sir_hold <= 4'h0;
        end
        else
        begin
            rx_sync <= {rx_sync[1:0], port0_serial_in_in};
            if (!rx_sync[2])
                sir_hold <= `AST_OVS_LAST;
            else if (oversample_tick && sir_hold != 4'h0)
                sir_hold <= sir_hold - 1'b1;
        end
    end

    // Transmitter: one oversample count of 16 per bit, start through stops.
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            tx_state <= S_IDLE;
            tx_ovs   <= 4'h0;
            tx_bit   <= 4'h0;
            tx_shift <= 8'h00;
            tx_line  <= 1'b1;
            txq_pop  <= 1'b0;
        end
        else
        begin
            txq_pop <= 1'b0;
            case (tx_state)
                S_IDLE:
                begin
                    tx_line <= 1'b1;
                    // A new frame starts only while enabled; a running one ignores the enable.
                    if (port_en && ctl_out[`AST_CTL_TXE] && txq_valid && !txq_pop)
                    begin
                        tx_shift <= txq_data;
                        txq_pop  <= 1'b1;
                        tx_state <= S_START;
                        tx_ovs   <= 4'h0;
                        tx_line  <= 1'b0;
                    end
                end
                S_START, S_DATA, S_PAR, S_STOP:
                begin
                    if (oversample_tick)
                    begin
                        tx_ovs <= tx_ovs + 1'b1;
                        if (tx_ovs == `AST_OVS_LAST)
                        begin
                            case (tx_state)
                                S_START:
                                begin
                                    tx_state <= S_DATA;
                                    tx_bit   <= 4'h1;
                                    tx_line  <= tx_shift[0];
                                    tx_shift <= tx_shift >> 1;
                                end
                                S_DATA:
                                begin
                                    if (tx_bit == nbits)
                                    begin
                                        tx_state <= pen ? S_PAR : S_STOP;
                                        tx_line  <= pen ? tx_line ^ 1'b0 : 1'b1;
                                        tx_bit   <= 4'h0;
                                    end
                                    else
                                    begin
                                        tx_bit   <= tx_bit + 1'b1;
                                        tx_line  <= tx_shift[0];
                                        tx_shift <= tx_shift >> 1;
                                    end
                                end
                                S_PAR:
                                begin
                                    tx_state <= S_STOP;
                                    tx_line  <= 1'b1;
                                    tx_bit   <= 4'h0;
                                end
                                default:
                                begin
                                    if (lcr[`AST_LCR_STP2] && tx_bit == 4'h0)
                                        tx_bit <= 4'h1;
                                    else
                                        tx_state <= S_IDLE;
                                end
                            endcase
                        end
                    end
                end
                default: tx_state <= S_IDLE;
            endcase
        end
    end

    // Parity is computed from the byte still held in the queue entry copy.
    reg [7:0] tx_byte;
    always @(posedge clk_in)
    begin
        if (rst_in)
            tx_byte <= 8'h00;
        else if (txq_pop)
            tx_byte <= txq_data;
    end

    // The parity level replaces the held line level only while the parity bit is on the wire.
    wire txd_now = (tx_state == S_PAR) ? par_bit(tx_byte, nbits, eps, sps) : tx_line;

    // Pin driver: plain levels, or a 3/16 high pulse per zero in infrared mode.
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            port0_serial_out_out <= 1'b1;
            busy_out             <= 1'b0;
        end
        else
        begin
            busy_out <= txq_valid | (tx_state != S_IDLE);
            if (!serial_function_out)
                port0_serial_out_out <= gpio_out_in;
            else if (sir_en)
                port0_serial_out_out <= !txd_now && (tx_ovs < `AST_SIR_PULSE);
            else
                port0_serial_out_out <= txd_now;
        end
    end

    // Receiver: start qualification at tick 7, then one sample per 16 ticks.
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rx_state <= S_IDLE;
            rx_prev  <= 1'b1;
            rx_ovs   <= 4'h0;
            rx_bit   <= 4'h0;
            rx_shift <= 8'h00;
            rx_pe    <= 1'b0;
            rx_zero  <= 1'b0;
            rx_push  <= 1'b0;
            rx_word  <= 12'h000;
            oe_pend  <= 1'b0;
        end
        else
        begin
            rx_push <= 1'b0;
            rx_prev <= rx_line;
            if (rx_push && !rxq_ready)
                oe_pend <= 1'b1;
            else if (rx_push)
                oe_pend <= 1'b0;
            case (rx_state)
                S_IDLE:
                begin
                    if (port_en && ctl_out[`AST_CTL_RXE] && rx_prev && !rx_line)
                    begin
                        rx_state <= S_START;
                        rx_ovs   <= 4'h0;
                    end
                end
                S_START:
                begin
                    if (oversample_tick)
                    begin
                        rx_ovs <= rx_ovs + 1'b1;
                        if (rx_ovs == `AST_START_CHECK)
                        begin
                            // A glitch shorter than half a bit is dropped here.
                            rx_state <= rx_line ? S_IDLE : S_DATA;
                            rx_ovs   <= 4'h0;
                            rx_bit   <= 4'h0;
                            rx_shift <= 8'h00;
                            rx_zero  <= 1'b1;
                        end
                    end
                end
                S_DATA, S_PAR, S_STOP:
                begin
                    if (oversample_tick)
                    begin
                        rx_ovs <= rx_ovs + 1'b1;
                        if (rx_ovs == `AST_OVS_LAST)
                        begin
                            if (rx_line)
                                rx_zero <= 1'b0;
                            case (rx_state)
                                S_DATA:
                                begin
                                    rx_shift <= {rx_line, rx_shift[7:1]};
                                    rx_bit   <= rx_bit + 1'b1;
                                    if (rx_bit + 1'b1 == nbits)
                                        rx_state <= pen ? S_PAR : S_STOP;
                                end
                                S_PAR:
                                begin
                                    rx_pe    <= (rx_line != par_bit(rx_shift >> (4'h8 - nbits),
                                                nbits, eps, sps));
                                    rx_state <= S_STOP;
                                end
                                default:
                                begin
                                    rx_push  <= 1'b1;
                                    rx_word[7:0]         <= rx_shift >> (4'h8 - nbits);
                                    rx_word[`AST_ST_FE]  <= !rx_line;
                                    rx_word[`AST_ST_PE]  <= pen & rx_pe;
                                    rx_word[`AST_ST_BE]  <= rx_zero & !rx_line;
                                    rx_word[`AST_ST_OE]  <= oe_pend;
                                    rx_pe    <= 1'b0;
                                    rx_state <= S_IDLE;
                                end
                            endcase
                        end
                    end
                end
                default: rx_state <= S_IDLE;
            endcase
        end
    end

    // Transmit queue; single-entry until queue enable is set.
    ast_queue #(.W(8), .D(QDEPTH), .AW(QAW)) u_txq (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .one_deep_in   (!queue_enable_bit),
        .in_valid_in   (tx_valid_in),
        .in_data_in    (tx_data_in),
        .in_ready_out  (tx_ready_out),
        .out_valid_out (txq_valid),
        .out_data_out  (txq_data),
        .out_ready_in  (txq_pop)
    );

    // Receive queue with four status bits per entry; a full queue sets overrun.
    ast_queue #(.W(12), .D(QDEPTH), .AW(QAW)) u_rxq (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .one_deep_in   (!queue_enable_bit),
        .in_valid_in   (rx_push),
        .in_data_in    (rx_word),
        .in_ready_out  (rxq_ready),
        .out_valid_out (rxq_valid),
        .out_data_out  (rxq_data),
        .out_ready_in  (rxb_ready)
    );

    // Two-entry buffer toward the reader; a stalled reader loses words once it and the receive queue are full.
    ast_queue #(.W(12), .D(2), .AW(1)) u_rxbuf (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .one_deep_in   (1'b0),
        .in_valid_in   (rxq_valid),
        .in_data_in    (rxq_data),
        .in_ready_out  (rxb_ready),
        .out_valid_out (rx_valid_out),
        .out_data_out  (rx_data_out),
        .out_ready_in  (rx_ready_in)
    );
endmodule // ast_transceiver

//--- src/ast_defs.vh
// Purpose: Shared constants of the asynchronous serial transceiver.
// Assumes: Included by the transceiver module by bare name.
// Notes:   Control and line-control field positions, reset values and tick counts.
`ifndef AST_DEFS_VH
`define AST_DEFS_VH

// Port control fields.
`define AST_CTL_W          4
`define AST_CTL_EN         0
`define AST_CTL_SIR        1
`define AST_CTL_TXE        2
`define AST_CTL_RXE        3
`define AST_CTL_RESET      4'hc

// Line control fields.
`define AST_LCR_W          8
`define AST_LCR_PEN        1
`define AST_LCR_EPS        2
`define AST_LCR_STP2       3
`define AST_LCR_FEN        4
`define AST_LCR_WLEN_LO    5
`define AST_LCR_WLEN_HI    6
`define AST_LCR_SPS        7
`define AST_LCR_RESET      8'h60

// Divisor widths and latched word layout.
`define AST_DIVI_W         16
`define AST_DIVF_W         6
`define AST_LATCH_W        30

// Oversampling counts and minimum word length.
`define AST_OVS_LAST       4'hf
`define AST_START_CHECK    4'h7
`define AST_MIN_BITS       4'h5
`define AST_SIR_PULSE      4'h3

// Receive status positions within a queue entry.
`define AST_ST_FE          8
`define AST_ST_PE          9
`define AST_ST_BE          10
`define AST_ST_OE          11

`endif

//--- src/ast_queue.v
// Purpose: Flip-flop queue with valid and ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   one_deep_in limits the queue to a single entry; valid and ready are registered.
`timescale 1ns/10ps
module ast_queue #(
    parameter W  = 8,
    parameter D  = 16,
    parameter AW = 4
)(
    input  wire          clk_in,
    input  wire          rst_in,
    input  wire          one_deep_in,
    input  wire          in_valid_in,
    input  wire [W-1:0]  in_data_in,
    output reg           in_ready_out,
    output reg           out_valid_out,
    output wire [W-1:0]  out_data_out,
    input  wire          out_ready_in
);
    reg  [W-1:0]  mem [0:D-1];
    reg  [AW-1:0] wr_ptr;
    reg  [AW-1:0] rd_ptr;
    reg  [AW:0]   count;
    reg  [AW:0]   next_count;
    wire          push = in_valid_in & in_ready_out;
    wire          pop  = out_valid_out & out_ready_in;
    wire [AW:0]   limit = one_deep_in ? {{AW{1'b0}}, 1'b1} : D[AW:0];

    assign out_data_out = mem[rd_ptr];

    // Occupancy after this cycle's push and pop.
    always @*
    begin
        next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // Pointers wrap at D; flags are registered so the ports come from flops.
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_ptr        <= {AW{1'b0}};
            rd_ptr        <= {AW{1'b0}};
            count         <= {(AW+1){1'b0}};
            in_ready_out  <= 1'b0;
            out_valid_out <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data_in;
                wr_ptr      <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            count         <= next_count;
            in_ready_out  <= (next_count < limit);
            out_valid_out <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule // ast_queue

//--- verification/ast_chk_asserts.sv
// Purpose: Port checks of the serial transceiver.
// Assumes: One clock, synchronous high reset, port 0.
// Notes:   Bit checks need a divisor of at least one.
`timescale 1ns/10ps
module ast_chk (
    input wire        clk_in,
    input wire        rst_in,
    input wire        ctl_wr_in,
    input wire [3:0]  ctl_data_in,
    input wire [3:0]  ctl_out,
    input wire        lcr_wr_in,
    input wire [7:0]  lcr_data_in,
    input wire [29:0] latched_out,
    input wire        tx_valid_in,
    input wire        tx_ready_out,
    input wire        rx_valid_out,
    input wire [11:0] rx_data_out,
    input wire        rx_ready_in,
    input wire        busy_out,
    input wire        serial_function_out,
    input wire        port0_serial_out_out
);
    // Reset is judged only where a property overrides the default.
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // The divisor word may move only on a line-control write.
    rst_val_a: assert property (disable iff (1'b0)
        rst_in |=> ctl_out == 4'hc && serial_function_out) else $error("bad reset");
    ctl_load_a: assert property (
        ctl_wr_in |=> ctl_out == $past(ctl_data_in)) else $error("bad control");
    lcr_hold_a: assert property (
        !lcr_wr_in |=> $stable(latched_out)) else $error("word moved");
    lcr_load_a: assert property (
        lcr_wr_in |=> latched_out[7:0] == $past(lcr_data_in)) else $error("bad latch");
    busy_set_a: assert property (
        tx_valid_in && tx_ready_out |=> ##[0:2] busy_out) else $error("no busy");
    busy_line_a: assert property (
        !port0_serial_out_out && !ctl_out[1] |-> busy_out) else $error("idle low");
    bit_len_a: assert property (
        $fell(port0_serial_out_out) && !ctl_out[1] |=> !port0_serial_out_out [*8])
        else $error("short bit");
    rx_hold_a: assert property (
        rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
        else $error("rx lost");
endmodule // ast_chk
bind ast_transceiver ast_chk u_chk (.clk_in, .rst_in, .ctl_wr_in, .ctl_data_in, .ctl_out,
    .lcr_wr_in, .lcr_data_in, .latched_out, .tx_valid_in, .tx_ready_out, .rx_valid_out,
    .rx_data_out, .rx_ready_in, .busy_out, .serial_function_out, .port0_serial_out_out);

//--- verification/ast_remote.sv
// Purpose: Remote serial node on the port pins.
// Assumes: BIT clocks per bit, line idles high.
// Notes:   Eight data bits, no parity, one stop.
`timescale 1ns/10ps
module ast_remote #(
    parameter BIT = 16
)(
    input  wire clk_in,
    input  wire line_in,
    output reg  line_out
);
    integer   i, j;
    reg [9:0] f, g;
    initial line_out = 1'b1;
    // Sends start, data low bit first, then a stop of level s.
    task send(input [7:0] d, input s);
    begin
        f = {s, d, 1'b0};
        for (i = 0; i < 10; i = i + 1)
        begin
            line_out = f[i];
            repeat (BIT) @(negedge clk_in);
        end
        line_out = 1'b1;
    end
    endtask
    // Samples mid-bit, so a wrong bit period shows as bad data.
    task recv(output [7:0] d, output s);
    begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge clk_in);
        for (j = 0; j < 9; j = j + 1)
        begin
            repeat (BIT) @(posedge clk_in);
            g[j] = line_in;
        end
        d = g[7:0];
        s = g[8];
    end
    endtask
endmodule // ast_remote

//--- verification/tb_top.sv
// Purpose: Self-checking bench of the transceiver.
// Assumes: Divisor 1.0, so one bit is 16 clocks.
// Notes:   Inputs change at the falling edge.
`timescale 1ns/10ps
module tb_top;
    reg         clk_in = 1'b0, rst_in = 1'b1, tx_valid_in = 1'b0, rx_ready_in = 1'b0;
    reg         ctl_wr_in = 1'b0, int_wr_in = 1'b0, frac_wr_in = 1'b0, lcr_wr_in = 1'b0;
    reg  [15:0] v = 16'h0000;
    reg  [7:0]  tx_data_in = 8'h00, d0, d1;
    reg         s0, s1;
    wire [3:0]  ctl_out;
    wire [29:0] latched_out;
    wire [11:0] rx_data_out;
    wire        tx_ready_out, rx_valid_out, busy_out, serial_function_out, rxl, txl;
    integer     miscompares = 0, checks_done = 0, cyc = 0;
    ast_transceiver u_dut (.clk_in, .rst_in, .ctl_wr_in, .ctl_data_in(v[3:0]), .ctl_out,
        .int_wr_in, .int_data_in(v), .frac_wr_in, .frac_data_in(v[5:0]), .lcr_wr_in,
        .lcr_data_in(v[7:0]), .latched_out, .tx_valid_in, .tx_data_in, .tx_ready_out,
        .rx_valid_out, .rx_data_out, .rx_ready_in, .busy_out, .alt_function_select_in(1'b0),
        .gpio_out_in(1'b1), .serial_function_out, .port0_serial_in_in(rxl),
        .port0_serial_out_out(txl));
    ast_remote u_rem (.clk_in, .line_in(txl), .line_out(rxl));
    // Clock, and a cycle ceiling so a hang still reaches the verdict.
    initial forever #12.5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            miscompares = miscompares + 1;
            summarize;
        end
    end
    task chk(input c);
    begin
        checks_done = checks_done + 1;
        if (c !== 1'b1)
        begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t check %0d", $time, checks_done);
        end
    end
    endtask
    task summarize;
    begin
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    // Strobe k: 0 control, 1 integer, 2 fraction, 3 line control.
    task reg_wr(input [1:0] k, input [15:0] x);
    begin
        @(negedge clk_in);
        v = x;
        {ctl_wr_in, int_wr_in, frac_wr_in, lcr_wr_in} = 4'h8 >> k;
        @(negedge clk_in);
        {ctl_wr_in, int_wr_in, frac_wr_in, lcr_wr_in} = 4'h0;
    end
    endtask
    // Ready is registered, so it is steady at the falling edge.
    task wr_tx(input [7:0] d);
    begin
        @(negedge clk_in);
        while (tx_ready_out !== 1'b1) @(negedge clk_in);
        tx_data_in = d;
        tx_valid_in = 1'b1;
        @(negedge clk_in);
        tx_valid_in = 1'b0;
    end
    endtask
    task rd(input [11:0] e);
        integer n;
    begin
        for (n = 0; n < 400 && rx_valid_out !== 1'b1; n = n + 1) @(negedge clk_in);
        chk(rx_data_out === e);
        rx_ready_in = 1'b1;
        @(negedge clk_in);
        rx_ready_in = 1'b0;
        @(negedge clk_in);
    end
    endtask
    // Two bytes back to back; busy holds through the last stop bit.
    task t_tx;
    begin
        fork
            begin wr_tx(8'ha5); wr_tx(8'h3c); end
            begin u_rem.recv(d0, s0); u_rem.recv(d1, s1); end
        join
        chk(d0 === 8'ha5 && s0 === 1'b1);
        chk(d1 === 8'h3c && s1 === 1'b1);
        chk(busy_out === 1'b1);
        repeat (40) @(negedge clk_in);
        chk(busy_out === 1'b0);
    end
    endtask
    // Disabling mid-character must still let the whole byte out.
    task t_off;
    begin
        fork
            wr_tx(8'h81);
            begin repeat (60) @(negedge clk_in); reg_wr(0, 16'h000c); end
            u_rem.recv(d0, s0);
        join
        chk(d0 === 8'h81 && busy_out === 1'b1);
        reg_wr(0, 16'h000d);
    end
    endtask
    // The receiver is stalled while a good frame, a glitch and two bad frames arrive.
    task t_rx;
    begin
        u_rem.send(8'h5a, 1'b1);
        u_rem.line_out = 1'b0;
        repeat (3) @(negedge clk_in);
        u_rem.line_out = 1'b1;
        repeat (40) @(negedge clk_in);
        u_rem.send(8'hc3, 1'b0);
        repeat (20) @(negedge clk_in);
        u_rem.send(8'h00, 1'b0);
        repeat (20) @(negedge clk_in);
        rd(12'h05a);
        rd(12'h1c3);
        rd(12'h500);
        chk(rx_valid_out === 1'b0);
    end
    endtask
    // Seven bits, even parity, two stops; bit 7 of the byte must stay off the line.
    task t_par;
    begin
        reg_wr(0, 16'h000c);
        reg_wr(3, 16'h005e);
        reg_wr(0, 16'h000d);
        fork
            wr_tx(8'hb1);
            u_rem.recv(d0, s0);
        join
        chk(d0 === 8'hb1 && s0 === 1'b1);
        repeat (16) @(negedge clk_in);
        chk(busy_out === 1'b1 && txl === 1'b1);
        repeat (20) @(negedge clk_in);
        chk(busy_out === 1'b0 && txl === 1'b1);
    end
    endtask
    initial
    begin
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        chk(ctl_out === 4'hc && serial_function_out === 1'b1);
        chk(latched_out === 30'h0 && busy_out === 1'b0 && txl === 1'b1);
        reg_wr(0, 16'h000c);
        reg_wr(1, 16'h0001);
        reg_wr(2, 16'h0000);
        chk(latched_out === 30'h0);
        reg_wr(3, 16'h0070);
        chk(latched_out === {16'h0001, 6'h00, 8'h70});
        reg_wr(0, 16'h000d);
        t_tx;
        t_off;
        t_rx;
        t_par;
        summarize;
    end
endmodule // tb_top
